// *** rtl/gsl_key_seq.sv ***
`timescale 1ns/10ps
module gsl_key_seq
    import gsl_pkg::*;
(
    input wire logic clk,             // bus clock
    input wire logic rst,             // async reset
    input wire logic wr,              // write to freeze reg
    input wire logic rd,              // read of freeze reg
    input wire logic wkey,            // key bit written
    input wire logic same_bits,       // pin bits match held value
    output logic key_on               // lock active
);
    typedef struct packed {
        gsl_key_e st;
    } gsl_ks_s;
    gsl_ks_s cur, next_cur;

    // armed from the cycle after the read
    assign key_on = (cur.st == KEY_ON) || (cur.st == KEY_RD0);

    always_comb
    begin
        next_cur = cur;
        case (cur.st)
            KEY_IDLE: if (wr && wkey) next_cur.st = KEY_W1;
            KEY_W1:
            begin
                if (wr) next_cur.st = (!wkey && same_bits) ? KEY_W0 : (wkey ? KEY_W1 : KEY_IDLE);
                else if (rd) next_cur.st = KEY_IDLE;
            end
            KEY_W0:
            begin
                if (wr) next_cur.st = (wkey && same_bits) ? KEY_W1B : KEY_IDLE;
                else if (rd) next_cur.st = KEY_IDLE;
            end
            KEY_W1B:
            begin
                if (rd) next_cur.st = KEY_RD0;
                else if (wr) next_cur.st = wkey ? KEY_W1 : KEY_IDLE;
            end
            KEY_RD0: next_cur.st = KEY_ON;
            KEY_ON: next_cur.st = KEY_ON;
            default: next_cur.st = KEY_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cur <= '{st: KEY_IDLE};
        else
            cur <= next_cur;
    end
endmodule

// *** rtl/gsl_pkg.sv ***
package gsl_pkg;
    localparam logic [7:0] OFS_SET_CLEAR = 8'h18;
    localparam logic [7:0] OFS_FREEZE = 8'h1c;
    localparam logic [7:0] OFS_ALT_LOW = 8'h20;
    localparam logic [7:0] OFS_ALT_HIGH = 8'h24;
    localparam logic [7:0] OFS_MODE = 8'h40;
    localparam logic [7:0] OFS_OTYPE = 8'h44;
    localparam logic [7:0] OFS_PULL = 8'h48;
    localparam logic [7:0] OFS_OUT_DATA = 8'h4c;
    localparam int CLEAR_LSB = 16;
    localparam int KEY_BIT = 16;
    localparam int SEL_W = 4;
    localparam logic [1:0] MODE_ALT = 2'b10;
    localparam logic [3:0] SEL_NONE = 4'hf;
    localparam logic [31:0] RST_FREEZE = 32'h0000_0000;
    localparam logic [31:0] RST_ALT_LOW_B = 32'hfff0_0fff;
    localparam logic [31:0] RST_ALT_LOW = 32'hffff_ffff;
    localparam logic [31:0] RST_ALT_HIGH_A = 32'h000f_ffff;
    localparam logic [31:0] RST_ALT_HIGH = 32'hffff_ffff;
    localparam logic [31:0] RST_MODE = 32'hffff_ffff;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [1:0] PORT_A = 2'd0;
    localparam logic [1:0] PORT_B = 2'd1;

    typedef enum logic [2:0] {KEY_IDLE, KEY_W1, KEY_W0, KEY_W1B, KEY_RD0, KEY_ON} gsl_key_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gsl_bus_s;

    typedef struct packed {
        logic [15:0] out_level;
        logic [15:0] freeze_bits;
        logic freeze_key_bit;
        logic [31:0] alt_low;
        logic [31:0] alt_high;
        logic [31:0] mode;
        logic [15:0] otype;
        logic [31:0] pull;
    } gsl_cfg_s;
endpackage

// *** rtl/gsl_port.sv ***
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - low-half ones set output bits
// - high-half ones clear output bits
// - set beats clear on same pin
// - set/clear register is write-only
// - key bit changes only by sequence
// - confirming read returns key zero, next read returns one
// - active key freezes lock register
// - broken sequence leaves key zero
// - pin bits writable only key zero
// - set pin bit locks its configuration
// - bits 31:17 stay zero
// - lock register resets to zero
// - pins 0-7 selectors in low register
// - pins 8-15 selectors in high register
// - code 15 means no function
// - low select reset per port
// - high select reset per port
// - selector used only in alt mode
// - output bits settable individually
module gsl_port
    import gsl_pkg::*;
#(
    parameter logic [1:0] PORT_ID = 2'd0
)(
    input wire logic clk,                 // bus clock
    input wire logic rst,                 // async reset
    input wire logic [7:0] addr,          // byte address
    input wire logic [31:0] wdata,        // write data
    input wire logic wr,                  // write strobe
    input wire logic rd,                  // read strobe
    output logic [31:0] rdata,            // read data, cycle after rd
    output logic [15:0] out_level,        // output data to pads
    output logic [31:0] pin_mode,         // 2-bit modes
    output logic [15:0] pin_otype,        // output type
    output logic [31:0] pin_pull,         // pull config
    output logic [63:0] alt_route,        // effective selector per pin
    output logic key_active               // lock key state
);
    typedef struct packed {
        gsl_cfg_s cfg;
        logic [31:0] rdata;
        logic [63:0] route;
        logic key;
    } gsl_state_s;
    gsl_state_s cur, next_cur;
    gsl_bus_s bus;
    logic key_on;
    logic [15:0] unlocked;
    logic [63:0] all_sel;

    function automatic logic [31:0] keep_bits(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [31:0] keep);
        keep_bits = (old & keep) | (nw & ~keep);
    endfunction

    function automatic logic [31:0] widen2(input logic [15:0] m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) r[2*i +: 2] = {2{m[i]}};
        widen2 = r;
    endfunction

    function automatic logic [31:0] widen4(input logic [7:0] m);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) r[4*i +: 4] = {4{m[i]}};
        widen4 = r;
    endfunction

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    gsl_key_seq u_key (
        .clk(clk),
        .rst(rst),
        .wr(bus.wr && bus.addr == OFS_FREEZE),
        .rd(bus.rd && bus.addr == OFS_FREEZE),
        .wkey(bus.wdata[KEY_BIT]),
        .same_bits(bus.wdata[15:0] == cur.cfg.freeze_bits),
        .key_on(key_on)
    );

    // pin frozen only while key active
    assign unlocked = key_on ? ~cur.cfg.freeze_bits : 16'hffff;
    assign all_sel = {cur.cfg.alt_high, cur.cfg.alt_low};

    always_comb
    begin
        next_cur = cur;
        next_cur.key = key_on;
        next_cur.cfg.freeze_key_bit = key_on;
        if (bus.wr)
        begin
            case (bus.addr)
                OFS_SET_CLEAR:
                begin
                    next_cur.cfg.out_level = cur.cfg.out_level & ~bus.wdata[31:CLEAR_LSB];
                    next_cur.cfg.out_level = next_cur.cfg.out_level | bus.wdata[15:0];
                end
                OFS_FREEZE:
                begin
                    // pin bits only while key zero
                    if (!key_on) next_cur.cfg.freeze_bits = bus.wdata[15:0];
                end
                OFS_ALT_LOW:
                    next_cur.cfg.alt_low = keep_bits(cur.cfg.alt_low, bus.wdata,
                                                     widen4(~unlocked[7:0]));
                OFS_ALT_HIGH:
                    next_cur.cfg.alt_high = keep_bits(cur.cfg.alt_high, bus.wdata,
                                                      widen4(~unlocked[15:8]));
                OFS_MODE:
                    next_cur.cfg.mode = keep_bits(cur.cfg.mode, bus.wdata, widen2(~unlocked));
                OFS_OTYPE:
                    next_cur.cfg.otype = 16'(keep_bits({16'h0000, cur.cfg.otype}, bus.wdata,
                                                       {16'h0000, ~unlocked}));
                OFS_PULL:
                    next_cur.cfg.pull = keep_bits(cur.cfg.pull, bus.wdata, widen2(~unlocked));
                OFS_OUT_DATA:
                    next_cur.cfg.out_level = bus.wdata[15:0];
                default:
                    next_cur.cfg = cur.cfg;
            endcase
        end
        // selector forwarded only in alt mode
        for (int p = 0; p < 16; p++)
            next_cur.route[4*p +: 4] = (next_cur.cfg.mode[2*p +: 2] == MODE_ALT)
                                       ? next_cur_sel(next_cur.cfg, p) : SEL_NONE;
        next_cur.rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            case (bus.addr)
                OFS_SET_CLEAR: next_cur.rdata = 32'h0000_0000;
                OFS_FREEZE: next_cur.rdata = {15'h0000, key_on, cur.cfg.freeze_bits};
                OFS_ALT_LOW: next_cur.rdata = cur.cfg.alt_low;
                OFS_ALT_HIGH: next_cur.rdata = cur.cfg.alt_high;
                OFS_MODE: next_cur.rdata = cur.cfg.mode;
                OFS_OTYPE: next_cur.rdata = {16'h0000, cur.cfg.otype};
                OFS_PULL: next_cur.rdata = cur.cfg.pull;
                OFS_OUT_DATA: next_cur.rdata = {16'h0000, cur.cfg.out_level};
                default: next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    function automatic logic [3:0] next_cur_sel(input gsl_cfg_s c, input int p);
        logic [63:0] s;
        s = {c.alt_high, c.alt_low};
        next_cur_sel = s[4*p +: 4];
    endfunction

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur.cfg.freeze_bits <= RST_FREEZE[15:0];
            cur.cfg.freeze_key_bit <= 1'b0;
            cur.cfg.out_level <= RST_HALF;
            cur.cfg.alt_low <= (PORT_ID == PORT_B) ? RST_ALT_LOW_B : RST_ALT_LOW;
            cur.cfg.alt_high <= (PORT_ID == PORT_A) ? RST_ALT_HIGH_A : RST_ALT_HIGH;
            cur.cfg.mode <= RST_MODE;
            cur.cfg.otype <= RST_HALF;
            cur.cfg.pull <= 32'h0000_0000;
            cur.rdata <= 32'h0000_0000;
            cur.route <= {16{SEL_NONE}};
            cur.key <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign out_level = cur.cfg.out_level;
    assign pin_mode = cur.cfg.mode;
    assign pin_otype = cur.cfg.otype;
    assign pin_pull = cur.cfg.pull;
    assign alt_route = cur.route;
    assign key_active = cur.key;

    a_set_priority: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == OFS_SET_CLEAR) |=>
        ((out_level & $past(wdata[15:0])) == $past(wdata[15:0])))
        else $error("set bit not high after set/clear write");

    a_clear_half: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == OFS_SET_CLEAR) |=>
        ((out_level & ($past(wdata[31:16]) & ~$past(wdata[15:0]))) == 16'h0000))
        else $error("clear bit not low");

    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == OFS_SET_CLEAR) |=>
        ((out_level & $past(wdata[15:0] & wdata[31:16])) == $past(wdata[15:0] & wdata[31:16])))
        else $error("clear beat set on same pin");

    a_out_untouched: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == OFS_SET_CLEAR) |=>
        (((out_level ^ $past(out_level)) & ~$past(wdata[15:0] | wdata[31:16]))
         == 16'h0000))
        else $error("untouched output bit changed");

    a_out_idle: assert property (@(posedge clk) disable iff (rst)
        !(wr && (addr == OFS_SET_CLEAR || addr == OFS_OUT_DATA)) |=> $stable(out_level))
        else $error("output data changed without a write");

    a_set_clr_read: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_SET_CLEAR) |=> rdata == 32'h0000_0000)
        else $error("set/clear register read not zero");

    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data without a read");

    a_key_sticky: assert property (@(posedge clk) disable iff (rst)
        key_active |=> key_active)
        else $error("key dropped without reset");

    a_key_mirror: assert property (@(posedge clk) disable iff (rst)
        key_on |=> key_active)
        else $error("key output not following sequencer");

    a_key_sequence: assert property (@(posedge clk) disable iff (rst)
        (!key_on ##1 key_on) |-> $past(rd && addr == OFS_FREEZE, 1))
        else $error("key armed without read step");

    a_key_needs_seq: assert property (@(posedge clk) disable iff (rst)
        (!key_on && !(rd && addr == OFS_FREEZE)) |=> !key_on)
        else $error("key armed outside the read step");

    a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
        key_on |=> $stable(cur.cfg.freeze_bits))
        else $error("pin freeze bits changed while locked");

    a_freeze_open: assert property (@(posedge clk) disable iff (rst)
        (!key_on && wr && addr == OFS_FREEZE) |=>
        cur.cfg.freeze_bits == $past(wdata[15:0]))
        else $error("pin freeze bits refused while open");

    a_key_readback: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_FREEZE) |=>
        (rdata[31:17] == 15'h0000 && rdata[16] == $past(key_on)))
        else $error("freeze register readback wrong");

    a_key_bit_reads: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_FREEZE && key_on) |=> rdata[16])
        else $error("armed key read as zero");

    a_key_reads_zero: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_FREEZE && !key_on) |=> !rdata[16])
        else $error("idle key read as one");

    a_alt_low_read: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_ALT_LOW) |=> rdata == $past(all_sel[31:0]))
        else $error("low selector readback wrong");

    a_alt_high_read: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_ALT_HIGH) |=> rdata == $past(all_sel[63:32]))
        else $error("high selector readback wrong");

    a_route_mode: assert property (@(posedge clk) disable iff (rst)
        pin_mode[1:0] != MODE_ALT |-> alt_route[3:0] == SEL_NONE)
        else $error("selector routed outside alt mode");

    a_route_pin0: assert property (@(posedge clk) disable iff (rst)
        pin_mode[1:0] == MODE_ALT |-> alt_route[3:0] == cur.cfg.alt_low[3:0])
        else $error("pin 0 route not its selector");

    a_route_pin8: assert property (@(posedge clk) disable iff (rst)
        pin_mode[17:16] == MODE_ALT |-> alt_route[35:32] == cur.cfg.alt_high[3:0])
        else $error("pin 8 route not its selector");

    a_locked_mode: assert property (@(posedge clk) disable iff (rst)
        (key_on && cur.cfg.freeze_bits[0]) |=>
        pin_mode[1:0] == $past(pin_mode[1:0]))
        else $error("locked pin mode changed");

    a_lock_alt: assert property (@(posedge clk) disable iff (rst)
        (key_on && cur.cfg.freeze_bits[0]) |=>
        cur.cfg.alt_low[3:0] == $past(cur.cfg.alt_low[3:0]))
        else $error("locked pin selector changed");

    a_otype_lock: assert property (@(posedge clk) disable iff (rst)
        (key_on && cur.cfg.freeze_bits[0]) |=> pin_otype[0] == $past(pin_otype[0]))
        else $error("locked pin output type changed");

    a_lock_free: assert property (@(posedge clk) disable iff (rst)
        (key_on && !cur.cfg.freeze_bits[0] && wr && addr == OFS_MODE) |=>
        pin_mode[1:0] == $past(wdata[1:0]))
        else $error("unlocked pin mode refused");

    // main scenarios reached
    c_key_armed: cover property (@(posedge clk) disable iff (rst) !key_active ##1 key_active);
    c_set_clr_both: cover property (@(posedge clk) disable iff (rst)
        wr && addr == OFS_SET_CLEAR && (wdata[15:0] & wdata[31:16]) != 16'h0000);
    c_alt_used: cover property (@(posedge clk) disable iff (rst) alt_route[3:0] != SEL_NONE);
    c_lock_refused: cover property (@(posedge clk) disable iff (rst)
        key_on && wr && addr == OFS_MODE && cur.cfg.freeze_bits != 16'h0000);
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
    import gsl_pkg::*;
;
    logic clk;
    logic rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [31:0] rdata_b;
    logic [15:0] out_level;
    logic [31:0] pin_mode;
    logic [15:0] pin_otype;
    logic [31:0] pin_pull;
    logic [63:0] alt_route;
    logic key_active;
    logic [31:0] got;
    logic [31:0] got_b;
    logic [31:0] lo_m;
    logic [31:0] hi_m;
    logic [31:0] md_m;
    logic [31:0] d;
    logic [15:0] out_m;
    int n_fail;
    int checks;

    gsl_port #(.PORT_ID(PORT_A)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .out_level(out_level), .pin_mode(pin_mode),
        .pin_otype(pin_otype), .pin_pull(pin_pull), .alt_route(alt_route),
        .key_active(key_active));
    // second port only to see the other reset pattern
    gsl_port #(.PORT_ID(PORT_B)) dut_b (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata_b), .out_level(), .pin_mode(), .pin_otype(),
        .pin_pull(), .alt_route(), .key_active());

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask

    task automatic idle();
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        idle();
        got = rdata;
        got_b = rdata_b;
    endtask

    function automatic logic [63:0] route(input logic [31:0] lo, hi, md);
        logic [63:0] r;
        r = {hi, lo};
        for (int p = 0; p < 16; p++)
            if (md[2*p+:2] != MODE_ALT)
                r[4*p+:4] = SEL_NONE;
        return r;
    endfunction

    // locked pins keep their old field
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [15:0] lk,
                                          input int w);
        logic [31:0] r;
        r = n;
        for (int p = 0; p * w < 32; p++)
            if (lk[p])
                for (int b = 0; b < w; b++)
                    r[p*w+b] = o[p*w+b];
        return r;
    endfunction

    task automatic key_seq(input logic [15:0] a, b, input logic [31:0] r1, r2);
        bus_wr(OFS_FREEZE, {16'h0001, a});
        bus_wr(OFS_FREEZE, {16'h0000, b});
        bus_wr(OFS_FREEZE, {16'h0001, b});
        bus_rd(OFS_FREEZE);
        chk("key read0", got, r1);
        bus_rd(OFS_FREEZE);
        chk("key read1", got, r2);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial
    begin
        void'($urandom(35));
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        out_m = 16'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus_rd(OFS_FREEZE);
        chk("lock rst", got, RST_FREEZE);
        bus_rd(OFS_ALT_LOW);
        chk("afl a", got, 32'hffff_ffff);
        chk("afl b", got_b, 32'hfff0_0fff);
        bus_rd(OFS_ALT_HIGH);
        chk("afh a", got, 32'h000f_ffff);
        chk("afh b", got_b, 32'hffff_ffff);
        bus_rd(OFS_SET_CLEAR);
        chk("setclr rd", got, 32'h0000_0000);
        bus_rd(8'h30);
        chk("unmapped", got, 32'h0000_0000);
        // set, clear, set wins, corners then random
        for (int i = 0; i < 24; i++)
        begin
            d = (i == 0) ? 32'hffff_0000 : (i == 1) ? 32'hffff_ffff :
                (i == 2) ? 32'h8001_8000 : $urandom;
            bus_wr(OFS_SET_CLEAR, d);
            idle();
            out_m = (out_m & ~d[31:16]) | d[15:0];
            chk("out_level", out_level, out_m);
        end
        // every selector code, then random modes
        for (int i = 0; i < 10; i++)
        begin
            lo_m = (i == 0) ? 32'h7654_3210 : $urandom;
            hi_m = (i == 0) ? 32'hfedc_ba98 : $urandom;
            md_m = (i < 2) ? 32'haaaa_aaaa : $urandom;
            bus_wr(OFS_ALT_LOW, lo_m);
            bus_wr(OFS_ALT_HIGH, hi_m);
            bus_wr(OFS_MODE, md_m);
            bus_rd(OFS_ALT_LOW);
            chk("afl rd", got, lo_m);
            bus_rd(OFS_ALT_HIGH);
            chk("afh rd", got, hi_m);
            chk("alt_route", alt_route, route(lo_m, hi_m, md_m));
        end
        key_seq(16'h0003, 16'h0005, 32'h0000_0005, 32'h0000_0005);
        // read inside the sequence aborts it
        bus_wr(OFS_FREEZE, 32'h0001_0005);
        bus_wr(OFS_FREEZE, 32'h0000_0005);
        bus_rd(OFS_FREEZE);
        key_seq(16'h0005, 16'h0005, 32'h0000_0005, 32'h0001_0005);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("key after rst", key_active, 1'b0);
        out_m = 16'h0000;
        bus_wr(OFS_FREEZE, 32'hfffe_00f0);
        bus_rd(OFS_FREEZE);
        chk("reserved", got, 32'h0000_00f0);
        bus_wr(OFS_ALT_LOW, 32'h7654_3210);
        bus_wr(OFS_MODE, 32'haaaa_aaaa);
        lo_m = 32'h7654_3210;
        hi_m = 32'h000f_ffff;
        md_m = 32'haaaa_aaaa;
        key_seq(16'h00f0, 16'h00f0, 32'h0000_00f0, 32'h0001_00f0);
        idle();
        idle();
        chk("key_active", key_active, 1'b1);
        bus_wr(OFS_FREEZE, 32'h0000_0000);
        bus_wr(OFS_ALT_LOW, 32'h0000_0000);
        bus_wr(OFS_MODE, 32'h0000_0000);
        bus_wr(OFS_SET_CLEAR, 32'h0000_ffff);
        bus_rd(OFS_FREEZE);
        chk("lock frozen", got, 32'h0001_00f0);
        lo_m = merge(lo_m, 32'h0000_0000, 16'h00f0, 4);
        md_m = merge(md_m, 32'h0000_0000, 16'h00f0, 2);
        chk("mode locked", pin_mode, md_m);
        bus_rd(OFS_ALT_LOW);
        chk("afl locked", got, lo_m);
        chk("route locked", alt_route, route(lo_m, hi_m, md_m));
        chk("out free", out_level, 16'hffff);
        bus_wr(OFS_OTYPE, 32'h0000_ffff);
        bus_wr(OFS_PULL, 32'hffff_ffff);
        bus_wr(OFS_OUT_DATA, 32'h0000_1234);
        idle();
        chk("otype locked", pin_otype, 16'hff0f);
        chk("pull locked", pin_pull, merge(32'h0000_0000, 32'hffff_ffff, 16'h00f0, 2));
        chk("out data", out_level, 16'h1234);
        summarize();
    end
endmodule
